// ===== logic/ppc_pkg.sv
// Purpose: Shared constants and carriers for the port pin pullup control block.
// Assumes: One 100 MHz clock, AHB-Lite register access, 32-bit data.
// Notes:   Every register takes one aligned word; unmapped reads return zero.
package ppc_pkg;

   localparam int unsigned PA_W = 4;
   localparam int unsigned PB_W = 6;
   localparam int unsigned PC_W = 2;
   localparam int unsigned PD_W = 7;
   localparam int unsigned PE_W = 2;

   localparam logic [7:0] OFF_DIR_A  = 8'h00;
   localparam logic [7:0] OFF_PUS_A  = 8'h04;
   localparam logic [7:0] OFF_KBF_A  = 8'h08;
   localparam logic [7:0] OFF_DIR_B  = 8'h0C;
   localparam logic [7:0] OFF_DIR_C  = 8'h10;
   localparam logic [7:0] OFF_PUS_C  = 8'h14;
   localparam logic [7:0] OFF_DIR_D  = 8'h18;
   localparam logic [7:0] OFF_PUS_D  = 8'h1C;
   localparam logic [7:0] OFF_FUN_D  = 8'h20;
   localparam logic [7:0] OFF_DIR_E  = 8'h24;
   localparam logic [7:0] OFF_FUN_E  = 8'h28;
   localparam logic [7:0] OFF_PUEN   = 8'h2C;
   localparam logic [7:0] OFF_STAT   = 8'h30;
   localparam logic [7:0] OFF_RSTREQ = 8'h34;

   localparam int unsigned FUN_D_SPI  = 0;
   localparam int unsigned FUN_D_TIM  = 1;
   localparam int unsigned FUN_E_SCI  = 0;
   localparam int unsigned PUEN_A_LSB = 0;
   localparam int unsigned PUEN_C_LSB = 4;
   localparam int unsigned PUEN_D_LSB = 6;
   localparam int unsigned STAT_IRQ   = 0;
   localparam int unsigned STAT_RPIN  = 1;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;

   // Configuration as seen by the pullup logic.
   typedef struct packed {
      logic [3:0] dir_a;
      logic [3:0] pus_a;
      logic [3:0] kbf_a;
      logic [5:0] dir_b;
      logic [1:0] dir_c;
      logic [1:0] pus_c;
      logic [6:0] dir_d;
      logic [6:0] pus_d;
      logic       spi_d;
      logic [2:0] tim_d;
      logic [1:0] dir_e;
      logic       sci_e;
   } ppc_cfg_t;

   // Pullup enables for the ports that have them.
   typedef struct packed {
      logic [3:0] pu_a;
      logic [1:0] pu_c;
      logic [6:0] pu_d;
   } ppc_pu_t;

endpackage

// ===== logic/ppc_sync.sv
// Purpose: Two-stage synchroniser for an asynchronous level.
// Assumes: Input may change at any time.
// Notes:   The first stage feeds only the second.
`timescale 1ns/10ps
module ppc_sync (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic async_in,
   output logic      sync_out
);
   typedef struct packed {
      logic s1;
      logic s2;
   } ppc_sync_st_t;

   ppc_sync_st_t st_q;
   ppc_sync_st_t st_d;

   always_comb begin
      st_d    = st_q;
      st_d.s1 = async_in;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '{s1: 1'b1, s2: 1'b1};
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.s2;
endmodule

// ===== logic/ppc_pullup.sv
// Purpose: Per-bit pullup enables from direction, selection and function.
// Assumes: Configuration is registered upstream.
// Notes:   Purely combinational; the top registers the result.
`timescale 1ns/10ps
module ppc_pullup (
   input  wire ppc_pkg::ppc_cfg_t cfg,
   output wire ppc_pkg::ppc_pu_t  pu
);
   genvar i;
   generate
      for (i = 0; i < ppc_pkg::PA_W; i++) begin : g_a
         assign pu.pu_a[i] = (cfg.pus_a[i] & ~cfg.dir_a[i]) | cfg.kbf_a[i];
      end
      for (i = 0; i < ppc_pkg::PC_W; i++) begin : g_c
         assign pu.pu_c[i] = cfg.pus_c[i] & ~cfg.dir_c[i];
      end
      for (i = 0; i < ppc_pkg::PD_W; i++) begin : g_d
         assign pu.pu_d[i] = cfg.pus_d[i] & ~cfg.dir_d[i];
      end
   endgenerate
endmodule

// ===== logic/ppc_top.sv
// Purpose: Pullup, pin function and reset pin control for the general ports.
// Assumes: AHB-Lite single word transfers, hclk at 100 MHz.
// Notes:   Pin outputs are registered; zero wait state bus responses.
`timescale 1ns/10ps
// Notes on behaviour
// - Only ports A, C and D have selectable input pullups.
// - Each pullup is selected per bit.
// - A bit set as output has its pullup off, unless it is a port A bit with its keyboard function on.
// - Each port A bit may act as a keyboard interrupt input.
// - Keyboard function forces the pullup on while active.
// - Port B has no pullup logic.
// - Port D low four bits serve SPI; upper three bits serve timers individually.
// - Port D pullups stay per-pin selectable in peripheral function.
// - Port E bits can serve as serial receive and transmit.
// - A low external reset pin resets the whole device.
// - The reset pin is driven low while any internal reset source asserts.
// - The external interrupt pin is asynchronous and synchronised internally.
module ppc_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        irq_pin_in,
   input  wire logic        rst_pin_in,
   input  wire logic        int_reset_src,
   output logic             rst_pin_out,
   output logic             rst_pin_oe,
   output logic             irq_sync,
   output logic [3:0]       pu_a,
   output logic [1:0]       pu_c,
   output logic [6:0]       pu_d,
   output logic [3:0]       kbd_sel_a,
   output logic [5:0]       dir_b_out,
   output logic             spi_sel_d,
   output logic [2:0]       tim_sel_d,
   output logic             sci_sel_e,
   output logic             sys_reset_n
);

   typedef struct packed {
      ppc_pkg::ppc_cfg_t cfg;
      logic              sw_rst;
      logic              ph_valid;
      logic              ph_write;
      logic [7:0]        ph_addr;
      logic [31:0]       rdata;
      ppc_pkg::ppc_pu_t  pu;
      logic              rst_oe;
      logic              rpin_s1;
      logic              rpin_s2;
      logic              sysrst_n;
   } ppc_st_t;

   ppc_st_t          st_q;
   ppc_st_t          st_d;
   ppc_pkg::ppc_pu_t pu_w;
   logic             irq_s;
   logic             take;

   ppc_pullup u_pullup (
      .cfg (st_q.cfg),
      .pu  (pu_w)
   );

   ppc_sync u_irq_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (irq_pin_in),
      .sync_out (irq_s)
   );

   assign take = hsel & hready & (htrans == ppc_pkg::HTRANS_NONSEQ);

   always_comb begin
      st_d = st_q;
      // Data phase of a previously taken write.
      if (st_q.ph_valid && st_q.ph_write) begin
         if (st_q.ph_addr == ppc_pkg::OFF_DIR_A) begin
            st_d.cfg.dir_a = hwdata[3:0];
         end else if (st_q.ph_addr == ppc_pkg::OFF_PUS_A) begin
            st_d.cfg.pus_a = hwdata[3:0];
         end else if (st_q.ph_addr == ppc_pkg::OFF_KBF_A) begin
            st_d.cfg.kbf_a = hwdata[3:0];
         end else if (st_q.ph_addr == ppc_pkg::OFF_DIR_B) begin
            st_d.cfg.dir_b = hwdata[5:0];
         end else if (st_q.ph_addr == ppc_pkg::OFF_DIR_C) begin
            st_d.cfg.dir_c = hwdata[1:0];
         end else if (st_q.ph_addr == ppc_pkg::OFF_PUS_C) begin
            st_d.cfg.pus_c = hwdata[1:0];
         end else if (st_q.ph_addr == ppc_pkg::OFF_DIR_D) begin
            st_d.cfg.dir_d = hwdata[6:0];
         end else if (st_q.ph_addr == ppc_pkg::OFF_PUS_D) begin
            st_d.cfg.pus_d = hwdata[6:0];
         end else if (st_q.ph_addr == ppc_pkg::OFF_FUN_D) begin
            st_d.cfg.spi_d = hwdata[ppc_pkg::FUN_D_SPI];
            st_d.cfg.tim_d = hwdata[ppc_pkg::FUN_D_TIM +: 3];
         end else if (st_q.ph_addr == ppc_pkg::OFF_DIR_E) begin
            st_d.cfg.dir_e = hwdata[1:0];
         end else if (st_q.ph_addr == ppc_pkg::OFF_FUN_E) begin
            st_d.cfg.sci_e = hwdata[ppc_pkg::FUN_E_SCI];
         end else if (st_q.ph_addr == ppc_pkg::OFF_RSTREQ) begin
            st_d.sw_rst = hwdata[0];
         end
      end
      // Address phase capture.
      st_d.ph_valid = take;
      st_d.ph_write = hwrite;
      st_d.ph_addr  = haddr[7:0];
      // Read data follows any write stored at the same edge.
      if (take && !hwrite) begin
         st_d.rdata = ppc_pkg::RESET_WORD;
         if (haddr[7:0] == ppc_pkg::OFF_DIR_A) begin
            st_d.rdata = 32'(st_d.cfg.dir_a);
         end else if (haddr[7:0] == ppc_pkg::OFF_PUS_A) begin
            st_d.rdata = 32'(st_d.cfg.pus_a);
         end else if (haddr[7:0] == ppc_pkg::OFF_KBF_A) begin
            st_d.rdata = 32'(st_d.cfg.kbf_a);
         end else if (haddr[7:0] == ppc_pkg::OFF_DIR_B) begin
            st_d.rdata = 32'(st_d.cfg.dir_b);
         end else if (haddr[7:0] == ppc_pkg::OFF_DIR_C) begin
            st_d.rdata = 32'(st_d.cfg.dir_c);
         end else if (haddr[7:0] == ppc_pkg::OFF_PUS_C) begin
            st_d.rdata = 32'(st_d.cfg.pus_c);
         end else if (haddr[7:0] == ppc_pkg::OFF_DIR_D) begin
            st_d.rdata = 32'(st_d.cfg.dir_d);
         end else if (haddr[7:0] == ppc_pkg::OFF_PUS_D) begin
            st_d.rdata = 32'(st_d.cfg.pus_d);
         end else if (haddr[7:0] == ppc_pkg::OFF_FUN_D) begin
            st_d.rdata = 32'({st_d.cfg.tim_d, st_d.cfg.spi_d});
         end else if (haddr[7:0] == ppc_pkg::OFF_DIR_E) begin
            st_d.rdata = 32'(st_d.cfg.dir_e);
         end else if (haddr[7:0] == ppc_pkg::OFF_FUN_E) begin
            st_d.rdata = 32'(st_d.cfg.sci_e);
         end else if (haddr[7:0] == ppc_pkg::OFF_PUEN) begin
            st_d.rdata[ppc_pkg::PUEN_A_LSB +: ppc_pkg::PA_W] = st_q.pu.pu_a;
            st_d.rdata[ppc_pkg::PUEN_C_LSB +: ppc_pkg::PC_W] = st_q.pu.pu_c;
            st_d.rdata[ppc_pkg::PUEN_D_LSB +: ppc_pkg::PD_W] = st_q.pu.pu_d;
         end else if (haddr[7:0] == ppc_pkg::OFF_STAT) begin
            st_d.rdata[ppc_pkg::STAT_IRQ]  = irq_s;
            st_d.rdata[ppc_pkg::STAT_RPIN] = st_q.rpin_s2;
         end else if (haddr[7:0] == ppc_pkg::OFF_RSTREQ) begin
            st_d.rdata = 32'(st_d.sw_rst);
         end
      end
      st_d.pu = pu_w;
      // Pin drive for any internal reset source.
      st_d.rst_oe = int_reset_src | st_q.sw_rst;
      st_d.rpin_s1 = rst_pin_in;
      st_d.rpin_s2 = st_q.rpin_s1;
      // A low reset pin resets the system, including a self-driven low.
      st_d.sysrst_n = st_q.rpin_s2;
      if (!st_q.rpin_s2) begin
         st_d.cfg    = '0;
         st_d.sw_rst = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q          <= '0;
         st_q.rpin_s1  <= 1'b1;
         st_q.rpin_s2  <= 1'b1;
         st_q.sysrst_n <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign hrdata      = st_q.rdata;
   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;
   assign rst_pin_out = 1'b0;
   assign rst_pin_oe  = st_q.rst_oe;
   assign irq_sync    = irq_s;
   assign pu_a        = st_q.pu.pu_a;
   assign pu_c        = st_q.pu.pu_c;
   assign pu_d        = st_q.pu.pu_d;
   assign kbd_sel_a   = st_q.cfg.kbf_a;
   assign dir_b_out   = st_q.cfg.dir_b;
   assign spi_sel_d   = st_q.cfg.spi_d;
   assign tim_sel_d   = st_q.cfg.tim_d;
   assign sci_sel_e   = st_q.cfg.sci_e;
   assign sys_reset_n = st_q.sysrst_n;

endmodule

// ===== sim/ppc_props.sv
// Purpose: Port level checks for the pullup control top.
// Assumes: One clock; hresetn is asynchronous and active low.
// Notes:   Bound to every ppc_top instance.
`timescale 1ns/10ps
module ppc_props (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       irq_pin_in,
   input wire logic       rst_pin_in,
   input wire logic       int_reset_src,
   input wire logic       rst_pin_out,
   input wire logic       rst_pin_oe,
   input wire logic       irq_sync,
   input wire logic [3:0] pu_a,
   input wire logic [6:0] pu_d,
   input wire logic [3:0] kbd_sel_a,
   input wire logic       spi_sel_d,
   input wire logic [2:0] tim_sel_d,
   input wire logic       sys_reset_n
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_pin_low; !rst_pin_in [*3]; endsequence
   sequence s_pin_high; rst_pin_in [*4]; endsequence
   property p_kbd_pu; kbd_sel_a != 4'h0 ##1 $stable(kbd_sel_a) |-> (pu_a & kbd_sel_a) == kbd_sel_a; endproperty
   property p_rst_drive; int_reset_src |=> rst_pin_oe; endproperty
   property p_rst_low; rst_pin_oe |-> !rst_pin_out; endproperty
   property p_pin_reset; s_pin_low |=> !sys_reset_n; endproperty
   property p_pin_release; s_pin_high |=> sys_reset_n; endproperty
   property p_irq_sync; $stable(irq_pin_in) [*3] |-> irq_sync == irq_pin_in; endproperty
   property p_fun_pu;
      sys_reset_n && ($changed(spi_sel_d) || $changed(tim_sel_d)) |=> $stable(pu_d);
   endproperty
   property p_bus; hreadyout && !hresp; endproperty
   a_kbd_pu: assert property (p_kbd_pu) else $error("kbd pullup off");
   a_rst_drive: assert property (p_rst_drive) else $error("reset pin not driven");
   a_rst_low: assert property (p_rst_low) else $error("reset pin driven high");
   a_pin_reset: assert property (p_pin_reset) else $error("pin reset missed");
   a_pin_release: assert property (p_pin_release) else $error("reset stuck");
   a_irq_sync: assert property (p_irq_sync) else $error("irq sync wrong");
   a_fun_pu: assert property (p_fun_pu) else $error("function moved pullup");
   a_bus: assert property (p_bus) else $error("bus answer wrong");
endmodule
bind ppc_top ppc_props ppc_props_inst (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
   .hresp(hresp), .irq_pin_in(irq_pin_in), .rst_pin_in(rst_pin_in),
   .int_reset_src(int_reset_src), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
   .irq_sync(irq_sync), .pu_a(pu_a), .pu_d(pu_d), .kbd_sel_a(kbd_sel_a),
   .spi_sel_d(spi_sel_d), .tim_sel_d(tim_sel_d), .sys_reset_n(sys_reset_n));

// ===== sim/ppc_board.sv
// Purpose: Board logic on the reset and interrupt pins.
// Assumes: The reset wire has a pullup.
// Notes:   The interrupt level moves off the clock grid.
`timescale 1ns/10ps
module ppc_board (
   input  wire logic rst_pin_oe,
   input  wire logic rst_pin_out,
   input  wire logic ext_low,
   input  wire logic irq_lvl,
   output logic      rst_pin_in,
   output logic      irq_pin_in
);
   assign rst_pin_in = ((rst_pin_oe && !rst_pin_out) || ext_low) ? 1'b0 : 1'b1;
   assign #3.3 irq_pin_in = irq_lvl;
endmodule

// ===== sim/testbench.sv
// Purpose: Register and pin tests for the pullup control top.
// Assumes: Zero wait state bus; board model on the pins.
// Notes:   Expected values come from the pullup equations.
`timescale 1ns/10ps
module testbench;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        irq_pin_in, rst_pin_in, int_reset_src, rst_pin_out, rst_pin_oe;
   logic        irq_sync, spi_sel_d, sci_sel_e, sys_reset_n, ext_low, irq_lvl;
   logic [1:0]  htrans, pu_c;
   logic [2:0]  hsize, tim_sel_d;
   logic [3:0]  pu_a, kbd_sel_a, mon;
   logic [5:0]  dir_b_out;
   logic [6:0]  pu_d;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int          n_errors, n_compared;
   assign hready = hreadyout;
   assign mon = {irq_sync, rst_pin_oe, sys_reset_n, hready};
   ppc_top ppc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_pin_in(irq_pin_in),
      .rst_pin_in(rst_pin_in), .int_reset_src(int_reset_src), .rst_pin_out(rst_pin_out),
      .rst_pin_oe(rst_pin_oe), .irq_sync(irq_sync), .pu_a(pu_a), .pu_c(pu_c), .pu_d(pu_d),
      .kbd_sel_a(kbd_sel_a), .dir_b_out(dir_b_out), .spi_sel_d(spi_sel_d),
      .tim_sel_d(tim_sel_d), .sci_sel_e(sci_sel_e), .sys_reset_n(sys_reset_n));
   ppc_board ppc_board_inst (.rst_pin_oe(rst_pin_oe), .rst_pin_out(rst_pin_out),
      .ext_low(ext_low), .irq_lvl(irq_lvl), .rst_pin_in(rst_pin_in), .irq_pin_in(irq_pin_in));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Waits on one monitored level; 0 ready, 1 system reset, 2 pin drive, 3 irq.
   task automatic wait_for(input int k, input logic v);
      int i;
      i = 0;
      @(posedge hclk);
      while (mon[k] !== v && i < 40) begin
         @(posedge hclk);
         i++;
      end
      if (i == 40) begin
         n_errors++;
         finish_test;
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= ppc_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      wait_for(0, 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      wait_for(0, 1'b1);
      rd = hrdata;
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      int_reset_src = 1'b0;
      ext_low = 1'b0;
      irq_lvl = 1'b1;
      n_errors = 0;
      n_compared = 0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, ppc_pkg::OFF_STAT, 32'h0000_0000);
      chk("stat", rd, 32'h0000_0003);
      bus(1'b0, 8'h3C, 32'h0000_0000);
      chk("unmapped", rd, 32'h0000_0000);
      $display("reset test done");
      bus(1'b1, ppc_pkg::OFF_PUS_A, 32'h0000_000F);
      bus(1'b1, ppc_pkg::OFF_DIR_A, 32'h0000_0005);
      bus(1'b1, ppc_pkg::OFF_PUS_C, 32'h0000_0003);
      bus(1'b1, ppc_pkg::OFF_DIR_C, 32'h0000_0001);
      bus(1'b1, ppc_pkg::OFF_PUS_D, 32'h0000_007F);
      bus(1'b1, ppc_pkg::OFF_DIR_D, 32'h0000_000F);
      repeat (3) @(posedge hclk);
      chk("pu_a", 32'(pu_a), 32'h0000_000A);
      chk("pu_c", 32'(pu_c), 32'h0000_0002);
      chk("pu_d", 32'(pu_d), 32'h0000_0070);
      bus(1'b0, ppc_pkg::OFF_PUEN, 32'h0000_0000);
      chk("puen", rd, 32'h0000_1C2A);
      bus(1'b1, ppc_pkg::OFF_KBF_A, 32'h0000_0003);
      repeat (3) @(posedge hclk);
      chk("pu_a", 32'(pu_a), 32'h0000_000B);
      chk("kbd", 32'(kbd_sel_a), 32'h0000_0003);
      bus(1'b1, ppc_pkg::OFF_DIR_A, 32'h0000_000F);
      repeat (3) @(posedge hclk);
      chk("pu_a", 32'(pu_a), 32'h0000_0003);
      $display("pullup test done");
      bus(1'b1, ppc_pkg::OFF_FUN_D, 32'h0000_000F);
      bus(1'b1, ppc_pkg::OFF_FUN_E, 32'h0000_0001);
      bus(1'b1, ppc_pkg::OFF_DIR_B, 32'h0000_003F);
      repeat (3) @(posedge hclk);
      chk("tim", 32'({spi_sel_d, tim_sel_d, sci_sel_e}), 32'h0000_001F);
      chk("dir_b", 32'(dir_b_out), 32'h0000_003F);
      chk("pu_d", 32'(pu_d), 32'h0000_0070);
      bus(1'b1, ppc_pkg::OFF_FUN_D, 32'h0000_0004);
      repeat (3) @(posedge hclk);
      chk("tim", 32'({spi_sel_d, tim_sel_d}), 32'h0000_0002);
      bus(1'b1, ppc_pkg::OFF_FUN_D, 32'h0000_0000);
      $display("function test done");
      int_reset_src <= 1'b1;
      wait_for(1, 1'b0);
      chk("oe", 32'(rst_pin_oe), 32'h0000_0001);
      int_reset_src <= 1'b0;
      wait_for(1, 1'b1);
      bus(1'b0, ppc_pkg::OFF_DIR_B, 32'h0000_0000);
      chk("dir_b", rd, 32'h0000_0000);
      chk("pu_d", 32'(pu_d), 32'h0000_0000);
      ext_low <= 1'b1;
      wait_for(1, 1'b0);
      chk("oe", 32'(rst_pin_oe), 32'h0000_0000);
      ext_low <= 1'b0;
      wait_for(1, 1'b1);
      bus(1'b1, ppc_pkg::OFF_RSTREQ, 32'h0000_0001);
      wait_for(2, 1'b1);
      wait_for(2, 1'b0);
      wait_for(1, 1'b1);
      bus(1'b0, ppc_pkg::OFF_RSTREQ, 32'h0000_0000);
      chk("rstreq", rd, 32'h0000_0000);
      $display("reset pin test done");
      irq_lvl <= 1'b0;
      wait_for(3, 1'b0);
      bus(1'b0, ppc_pkg::OFF_STAT, 32'h0000_0000);
      chk("stat", rd, 32'h0000_0002);
      irq_lvl <= 1'b1;
      wait_for(3, 1'b1);
      $display("irq test done");
      finish_test;
   end
endmodule
